// ### hdl/isbc_top.sv
// optical black clamp, dc subtract, colour tagging and output start address
//
// Contract
// R1: high register bits 6-0 give upper address
// R2: low register gives lower sixteen address bits
// R3: byte address is base plus value times 32
// R4: shadowed settings take effect at vertical sync
// R5: clamp enable uses optical black average
// R6: software keeps clamp off for luma/chroma input
// R7: pixel count code selects 2,4,8,16
// R8: sampling starts at programmed count after hsync
// R9: line count code selects 2,4,8,16
// R10: clamp off subtracts fixed dc level
// R11: two-bit entries decode to colour class
// R12: mosaic uses line parity for positions
// R13: stripe maps positions 0,1,2 along line
// R14: mean of samples subtracted, saturating zero
// R15: field id selects first or second field
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "isbc_cfg.svh"
module isbc_top (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [`ISBC_ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [15:0]              o_rdata,
  input  wire logic                     i_vertical_sync,
  input  wire logic                     i_horizontal_sync,
  input  wire logic                     i_field_id,
  input  wire logic                     i_pix_valid,
  input  wire logic [13:0]              i_pix_data,
  output isbc_pkg::isbc_pixel_type      o_pixel,
  output logic      [31:0]              o_start_byte_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: sensor pins arrive from outside this domain

  logic [1:0]  vs_sync;
  logic [1:0]  hs_sync;
  logic [1:0]  fid_sync;
  logic [1:0]  pv_sync;
  logic [13:0] pd_meta;
  logic [13:0] pd_sync;
  logic        vs_prev;
  logic        hs_prev;

  // each pin has its own pair of flops; edge detectors read only the second
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vs_sync <= 2'h0;
      vs_prev <= 1'b0;
    end else begin
      vs_sync <= {vs_sync[0], i_vertical_sync};
      vs_prev <= vs_sync[1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hs_sync <= 2'h0;
      hs_prev <= 1'b0;
    end else begin
      hs_sync <= {hs_sync[0], i_horizontal_sync};
      hs_prev <= hs_sync[1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fid_sync <= 2'h0;
    end else begin
      fid_sync <= {fid_sync[0], i_field_id};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pv_sync <= 2'h0;
    end else begin
      pv_sync <= {pv_sync[0], i_pix_valid};
    end
  end

  // data rides beside its valid through the same depth, so they stay paired
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_meta <= 14'h0000;
      pd_sync <= 14'h0000;
    end else begin
      pd_meta <= i_pix_data;
      pd_sync <= pd_meta;
    end
  end

  logic vs_event;
  logic hs_event;
  assign vs_event = vs_sync[1] & ~vs_prev;
  assign hs_event = hs_sync[1] & ~hs_prev;

  ////////////////////////////////////////////////////////////////////////////
  // software-side shadow registers

  isbc_pkg::isbc_cfg_type shadow;
  isbc_pkg::isbc_cfg_type active;
  logic [31:0]            mem_base;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shadow <= '0;
    end else if (i_wr) begin
      if (i_addr == `ISBC_OFS_ADDR_HIGH) begin
        shadow.start_addr_upper_bits <= i_wdata[6:0]; // R1
      end else if (i_addr == `ISBC_OFS_ADDR_LOW) begin
        shadow.start_addr_lower_bits <= i_wdata; // R2
      end else if (i_addr == `ISBC_OFS_CLAMP) begin
        shadow.black_clamp_enable       <= i_wdata[`ISBC_CLAMP_EN_BIT];
        shadow.black_sample_pixel_count <= i_wdata[14:13];
        shadow.black_sample_start_pixel <= i_wdata[12:0];
      end else if (i_addr == `ISBC_OFS_DC_LEVEL_AND_BLACK_LINES) begin
        shadow.black_sample_line_count <= i_wdata[15:14];
        shadow.fixed_dc_subtract_level <= i_wdata[13:0];
      end else if (i_addr == `ISBC_OFS_COLOR) begin
        shadow.color_pattern <= i_wdata;
      end else if (i_addr == `ISBC_OFS_MODE) begin
        shadow.arrange <= isbc_pkg::isbc_arrange_type'(i_wdata[0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory base, not shadowed: set it once before capture starts
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_base <= `ISBC_BASE_RESET;
    end else if (i_wr) begin
      if (i_addr == `ISBC_OFS_BYTE_HI) begin
        mem_base[31:16] <= i_wdata;
      end else if (i_addr == `ISBC_OFS_BYTE_LO) begin
        mem_base[15:0] <= i_wdata;
      end
    end
  end

  // copied as one word so a frame never sees half an update
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active <= '0;
    end else if (vs_event) begin
      active <= shadow; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output start address

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_start_byte_addr <= 32'h0000_0000;
    end else begin
      o_start_byte_addr <= mem_base + {4'h0, active.start_addr_upper_bits,
        active.start_addr_lower_bits, 5'h00}; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // optical black sampling

  function automatic logic [4:0] isbc_code_count(input logic [1:0] code);
    isbc_code_count = 5'h02 << code; // R7 R9
  endfunction : isbc_code_count

  logic [12:0] pix_cnt;
  logic [4:0]  obs_pix;
  logic [4:0]  obs_line;
  logic        line_sampled;
  logic        frame_done;
  logic [21:0] obs_sum;
  logic [13:0] clamp_level;
  logic        line_odd;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pix_cnt <= 13'h0000;
    end else if (vs_event || hs_event) begin
      pix_cnt <= 13'h0000;
    end else if (pv_sync[1]) begin
      pix_cnt <= pix_cnt + 13'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_odd <= 1'b0;
    end else if (vs_event) begin
      line_odd <= 1'b0;
    end else if (hs_event) begin
      line_odd <= ~line_odd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line timing in pixel clocks, valid or not
  // holds at the top so a very long line never wraps into the window
  logic [12:0] clk_cnt;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_cnt <= 13'h0000;
    end else if (hs_event) begin
      clk_cnt <= 13'h0000;
    end else if (clk_cnt != 13'h1FFF) begin
      clk_cnt <= clk_cnt + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stripe position kept as a counter so no divider is built
  logic [1:0] stripe_pos;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stripe_pos <= 2'h0;
    end else if (vs_event || hs_event) begin
      stripe_pos <= 2'h0;
    end else if (pv_sync[1]) begin
      stripe_pos <= (stripe_pos == 2'h2) ? 2'h0 : stripe_pos + 2'h1;
    end
  end

  logic in_window;
  assign in_window = pv_sync[1] && !frame_done
    && clk_cnt >= active.black_sample_start_pixel // R8
    && obs_pix < isbc_code_count(active.black_sample_pixel_count); // R7

  // the sum is reset every frame, so the clamp tracks slow black drift
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      obs_pix      <= 5'h00;
      obs_line     <= 5'h00;
      line_sampled <= 1'b0;
      frame_done   <= 1'b0;
      obs_sum      <= 22'h000000;
      clamp_level  <= 14'h0000;
    end else if (vs_event) begin
      obs_pix      <= 5'h00;
      obs_line     <= 5'h00;
      line_sampled <= 1'b0;
      frame_done   <= 1'b0;
      obs_sum      <= 22'h000000;
    end else if (hs_event) begin
      obs_pix      <= 5'h00;
      line_sampled <= 1'b0;
      if (line_sampled && !frame_done) begin
        if (obs_line + 5'h01 == isbc_code_count(active.black_sample_line_count)) begin // R9
          frame_done  <= 1'b1;
          // divide by pixels times lines, both powers of two
          clamp_level <= 14'(obs_sum >> (5'h02 + {3'h0, active.black_sample_pixel_count}
            + {3'h0, active.black_sample_line_count})); // R14
        end
        obs_line <= obs_line + 5'h01;
      end
    end else if (in_window) begin
      obs_sum      <= obs_sum + {8'h00, pd_sync};
      obs_pix      <= obs_pix + 5'h01;
      line_sampled <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel correction and colour tagging

  logic [13:0] sub_level;
  logic [1:0]  pos;
  logic [7:0]  field_pat;

  assign sub_level = active.black_clamp_enable ? clamp_level // R5
                                               : active.fixed_dc_subtract_level; // R10
  assign field_pat = i_field_id_sel(fid_sync[1]);

  function automatic logic [7:0] i_field_id_sel(input logic fid);
    i_field_id_sel = fid ? active.color_pattern[15:8] : active.color_pattern[7:0]; // R15
  endfunction : i_field_id_sel

  always_comb begin
    if (active.arrange == isbc_pkg::ISBC_STRIPE) begin
      pos = stripe_pos; // R13
    end else begin
      pos = {line_odd, pix_cnt[0]}; // R12
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pixel <= '0;
    end else begin
      o_pixel.valid <= pv_sync[1];
      o_pixel.data  <= (pd_sync > sub_level) ? pd_sync - sub_level : 14'h0000; // R14
      o_pixel.color <= isbc_pkg::isbc_color_type'(field_pat[7 - 2*pos -: 2]); // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      if (i_addr == `ISBC_OFS_ADDR_HIGH) begin
        o_rdata <= {9'h000, shadow.start_addr_upper_bits}; // R1
      end else if (i_addr == `ISBC_OFS_ADDR_LOW) begin
        o_rdata <= shadow.start_addr_lower_bits;
      end else if (i_addr == `ISBC_OFS_CLAMP) begin
        o_rdata <= {shadow.black_clamp_enable, shadow.black_sample_pixel_count,
          shadow.black_sample_start_pixel};
      end else if (i_addr == `ISBC_OFS_DC_LEVEL_AND_BLACK_LINES) begin
        o_rdata <= {shadow.black_sample_line_count, shadow.fixed_dc_subtract_level};
      end else if (i_addr == `ISBC_OFS_COLOR) begin
        o_rdata <= shadow.color_pattern;
      end else if (i_addr == `ISBC_OFS_MODE) begin
        o_rdata <= {15'h0000, shadow.arrange};
      end else if (i_addr == `ISBC_OFS_STATUS) begin
        o_rdata <= {1'b0, frame_done, clamp_level};
      end else if (i_addr == `ISBC_OFS_BYTE_HI) begin
        o_rdata <= mem_base[31:16];
      end else if (i_addr == `ISBC_OFS_BYTE_LO) begin
        o_rdata <= mem_base[15:0];
      end else begin
        o_rdata <= 16'h0000;
      end
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule : isbc_top

// ### inc/isbc_cfg.svh
// offsets, field positions, reset values, address width and unit shift for the black clamp block
`ifndef ISBC_CFG_SVH
`define ISBC_CFG_SVH
`define ISBC_ADDR_W          4
`define ISBC_OFS_ADDR_HIGH   4'h0
`define ISBC_OFS_ADDR_LOW    4'h1
`define ISBC_OFS_CLAMP       4'h2
`define ISBC_OFS_DC_LEVEL_AND_BLACK_LINES       4'h3
`define ISBC_OFS_COLOR       4'h4
`define ISBC_OFS_MODE        4'h5
`define ISBC_OFS_STATUS      4'h6
`define ISBC_OFS_BYTE_HI     4'h7
`define ISBC_OFS_BYTE_LO     4'h8
`define ISBC_HIGH_MASK       16'h007F
`define ISBC_CLAMP_EN_BIT    15
`define ISBC_CLAMP_RESET     16'h0000
`define ISBC_ADDR_RESET      16'h0000
`define ISBC_DC_LEVEL_AND_BLACK_LINES_RESET     16'h0000
`define ISBC_COLOR_RESET     16'h0000
`define ISBC_UNIT_SHIFT      5
`define ISBC_BASE_RESET      32'h0000_0000
`endif

// ### inc/isbc_pkg.sv
// types for the black clamp and output address block
package isbc_pkg;
  typedef enum logic [1:0] {
    ISBC_RED_YE,
    ISBC_GR_CY,
    ISBC_GB_G,
    ISBC_B_MG
  } isbc_color_type;

  typedef enum logic {
    ISBC_MOSAIC,
    ISBC_STRIPE
  } isbc_arrange_type;

  typedef struct packed {
    logic [6:0]  start_addr_upper_bits;
    logic [15:0] start_addr_lower_bits;
    logic        black_clamp_enable;
    logic [1:0]  black_sample_pixel_count;
    logic [12:0] black_sample_start_pixel;
    logic [1:0]  black_sample_line_count;
    logic [13:0] fixed_dc_subtract_level;
    logic [15:0] color_pattern;
    isbc_arrange_type arrange;
  } isbc_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [13:0] data;
    isbc_color_type color;
  } isbc_pixel_type;
endpackage : isbc_pkg

// ### testbench/isbc_properties.sv
// port assertions for the black clamp block
`timescale 1ns/1ps
`include "isbc_cfg.svh"
module isbc_props (
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst_n,
  input wire logic [`ISBC_ADDR_W-1:0] i_addr,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [15:0]             o_rdata,
  input wire logic                    i_vertical_sync,
  input wire logic                    i_pix_valid,
  input wire logic [13:0]             i_pix_data,
  input wire isbc_pkg::isbc_pixel_type o_pixel,
  input wire logic [31:0]             o_start_byte_addr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_HIGH_ZERO: assert property ($past(i_rd) && $past(i_addr) == `ISBC_OFS_ADDR_HIGH
    |-> o_rdata[15:7] == 9'h000) else $error("upper address bits not zero");
  AST_STAT_MSB: assert property ($past(i_rd) && $past(i_addr) == `ISBC_OFS_STATUS
    |-> !o_rdata[15]) else $error("status top bit set");
  AST_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) > `ISBC_OFS_BYTE_LO
    |-> o_rdata == 16'h0000) else $error("unmapped read not zero");
  AST_PIX_LAT: assert property (o_pixel.valid |-> $past(i_pix_valid, 3))
    else $error("pixel out without pixel in");
  AST_PIX_NONE: assert property ($past(i_pix_valid, 3) |-> o_pixel.valid)
    else $error("pixel in lost");
  AST_DATA_LE: assert property (o_pixel.valid |-> o_pixel.data <= $past(i_pix_data, 3))
    else $error("subtract raised the pixel");
  // a change needs a frame start or a base write shortly before
  AST_ADDR_HOLD: assert property ($changed(o_start_byte_addr) |-> $past(i_wr)
    || $past(i_wr, 2) || $past(i_vertical_sync, 3) || $past(i_vertical_sync, 4))
    else $error("address changed mid frame");
endmodule : isbc_props
bind isbc_top isbc_props u_props (.i_ref_clk, .i_rst_n, .i_addr, .i_wr, .i_rd, .o_rdata,
  .i_vertical_sync, .i_pix_valid, .i_pix_data, .o_pixel, .o_start_byte_addr);

// ### testbench/isbc_sensor.sv
// raw sensor front end model: syncs and pixel stream
`timescale 1ns/1ps
module isbc_sensor (
  input  wire logic  i_ref_clk,
  output logic       o_vsync,
  output logic       o_hsync,
  output logic       o_pix_valid,
  output logic [13:0] o_pix_data
);
  // raw data only, so clamping may be on
  initial begin
    o_vsync = 1'b0;
    o_hsync = 1'b0;
    o_pix_valid = 1'b0;
    o_pix_data = 14'h0000;
  end
  task automatic vsync_pulse();
    @(posedge i_ref_clk) o_vsync <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    o_vsync <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask : vsync_pulse
  task automatic line(input int n, input logic [13:0] va, vb, input int s, w);
    @(posedge i_ref_clk) o_hsync <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    o_hsync <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    for (int i = 0; i < n; i++) begin
      o_pix_valid <= 1'b1;
      o_pix_data <= (i >= s && i < s + w) ? vb : va;
      @(posedge i_ref_clk);
    end
    // data no longer held, so it must not look valid
    o_pix_valid <= 1'b0;
    o_pix_data <= ~o_pix_data;
    repeat (8) @(posedge i_ref_clk);
  endtask : line
endmodule : isbc_sensor

// ### testbench/tb.sv
// self-checking bench for the black clamp block
`timescale 1ns/1ps
`include "isbc_cfg.svh"
module tb;
  logic i_ref_clk, i_rst_n, i_wr, i_rd, i_vertical_sync, i_horizontal_sync;
  logic i_field_id, i_pix_valid;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic [13:0] i_pix_data;
  logic [31:0] o_start_byte_addr;
  isbc_pkg::isbc_pixel_type o_pixel, q[$];
  int err_count = 0, n_checks = 0;
  always #20 i_ref_clk = ~i_ref_clk;
  isbc_top u_isbc_top (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_vertical_sync, .i_horizontal_sync, .i_field_id, .i_pix_valid, .i_pix_data,
    .o_pixel, .o_start_byte_addr);
  isbc_sensor u_isbc_sensor (.i_ref_clk, .o_vsync(i_vertical_sync),
    .o_hsync(i_horizontal_sync), .o_pix_valid(i_pix_valid), .o_pix_data(i_pix_data));
  always @(posedge i_ref_clk) if (o_pixel.valid === 1'b1) q.push_back(o_pixel);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk({16'h0000, o_rdata}, {16'h0000, e});
  endtask : rd
  task automatic pix(input logic [13:0] d, input logic [1:0] c);
    isbc_pkg::isbc_pixel_type p;
    p = q.pop_front();
    chk({16'h0000, p.data, p.color}, {16'h0000, d, c});
  endtask : pix
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    #(40 * 5000);
    err_count++;
    complete_run();
  end
  initial begin
    {i_ref_clk, i_rst_n, i_wr, i_rd, i_field_id, i_addr, i_wdata} = '0;
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 10; a++) rd(a[3:0], 16'h0000);
    wr(`ISBC_OFS_ADDR_HIGH, 16'hFFFF);
    wr(`ISBC_OFS_ADDR_LOW, 16'h1234);
    wr(`ISBC_OFS_BYTE_HI, 16'h0001);
    wr(`ISBC_OFS_BYTE_LO, 16'h0020);
    rd(`ISBC_OFS_ADDR_HIGH, 16'h007F);
    chk(o_start_byte_addr, 32'h0001_0020);
    u_isbc_sensor.vsync_pulse();
    chk(o_start_byte_addr, 32'h0001_0020 + (32'h007F_1234 << 5));
    wr(`ISBC_OFS_DC_LEVEL_AND_BLACK_LINES, 16'h0010);
    wr(`ISBC_OFS_COLOR, 16'hE41B);
    u_isbc_sensor.vsync_pulse();
    u_isbc_sensor.line(3, 14'h0100, 14'h0005, 1, 1);
    pix(14'h00F0, 2'h2);
    pix(14'h0000, 2'h3);
    pix(14'h00F0, 2'h2);
    u_isbc_sensor.line(2, 14'h0020, 14'h0020, 0, 0);
    pix(14'h0010, 2'h0);
    pix(14'h0010, 2'h1);
    wr(`ISBC_OFS_MODE, 16'h0001);
    i_field_id <= 1'b1;
    u_isbc_sensor.vsync_pulse();
    u_isbc_sensor.line(4, 14'h0011, 14'h0011, 0, 0);
    pix(14'h0001, 2'h3);
    pix(14'h0001, 2'h2);
    pix(14'h0001, 2'h1);
    pix(14'h0001, 2'h3);
    // clamp on: pixel i sits at clock count 7 + i, so start 0Bh takes pixels 4 and 5
    wr(`ISBC_OFS_MODE, 16'h0000);
    i_field_id <= 1'b0;
    wr(`ISBC_OFS_CLAMP, 16'h800B);
    u_isbc_sensor.vsync_pulse();
    q.delete();
    repeat (2) u_isbc_sensor.line(8, 14'h3FFF, 14'h0040, 4, 2);
    u_isbc_sensor.line(1, 14'h0050, 14'h0050, 0, 0);
    repeat (16) void'(q.pop_front());
    pix(14'h0010, 2'h2);
    complete_run();
  end
endmodule : tb
